// [bench/hpc_host_model.sv]
// Behavioural external host on the multiplexed parallel bus.
// Assumes the bench calls its tasks; pins change only after rising edges.
`timescale 1ns/10ps
module hpc_host_model
(
  // Clock
  input wire clk,
  // From the port
  input wire port_ready_out,
  input wire [15:0] host_data_out,
  input wire host_data_oe,
  // To the port
  output logic reg_select_0 = 1'b0,
  output logic reg_select_1 = 1'b0,
  output logic addr_strobe_n = 1'b1,
  output logic port_chip_select_n = 1'b1,
  output logic data_strobe_1_n = 1'b1,
  output logic data_strobe_2_n = 1'b1,
  output logic transfer_direction = 1'b1,
  output logic [15:0] host_data_in = 16'h0000
);
  task automatic xfer(input logic [1:0] sel, input logic rd, input logic [15:0] d,
    output logic [15:0] q);
    int n;
    n = 0;
    while (port_ready_out !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    {reg_select_1, reg_select_0} <= sel;
    transfer_direction <= rd;
    // Released lines show the inverse so a stale value never reads as good
    host_data_in <= rd ? ~host_data_in : d;
    port_chip_select_n <= 1'b0;
    @(posedge clk);
    data_strobe_1_n <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!(port_ready_out === 1'b0 && (!rd || host_data_oe === 1'b1)) && n < 20);
    // Undriven lines read as the inverse, so a missing enable shows up
    q = (host_data_oe === 1'b1) ? host_data_out : ~host_data_out;
    data_strobe_1_n <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (port_ready_out !== 1'b1 && n < 20);
    port_chip_select_n <= 1'b1;
    host_data_in <= ~host_data_in;
  endtask
  task automatic alat(input logic [15:0] d);
    @(posedge clk);
    host_data_in <= d;
    @(posedge clk);
    addr_strobe_n <= 1'b0;
    repeat (4) @(posedge clk);
    addr_strobe_n <= 1'b1;
    repeat (4) @(posedge clk);
    host_data_in <= ~d;
  endtask
endmodule // hpc_host_model

// [bench/hpc_port_assertions.sv]
// Pin-level checks of the host port, seen from its ports only.
// Assumes one clock and the async active-low reset of the top.
`timescale 1ns/10ps
module hpc_port_assertions
(
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Host pins
  input wire float_n,
  input wire port_chip_select_n,
  input wire data_strobe_1_n,
  input wire data_strobe_2_n,
  input wire transfer_direction,
  input wire bus_mux_select,
  input wire ext_interface_select,
  input wire port_reset_n,
  // Host outputs
  input wire host_data_oe,
  input wire port_ready_out,
  input wire port_ready_oe,
  input wire subsys_a_host_irq_oe,
  input wire subsys_b_host_irq_oe,
  input wire subsys_reset_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Sync delay plus output register fits in four cycles
  float_off_a: assert property ((!float_n)[*4] |-> !host_data_oe && !port_ready_oe
    && !subsys_a_host_irq_oe && !subsys_b_host_irq_oe) else $error("pins driven in float");
  nonmux_irq_off_a: assert property (bus_mux_select[*4] |->
    !subsys_a_host_irq_oe && !subsys_b_host_irq_oe) else $error("irq driven in nonmux");
  port_reset_a: assert property ((!port_reset_n)[*6] |-> !subsys_reset_n)
    else $error("subsystem reset missing");
  chip_sel_a: assert property (port_chip_select_n[*6] |-> !host_data_oe)
    else $error("data driven without chip select");
  ext_sel_a: assert property (ext_interface_select[*6] |-> !host_data_oe)
    else $error("data driven in memory mode");
  ready_busy_a: assert property (host_data_oe |-> !port_ready_out)
    else $error("ready during transfer");
  write_dir_a: assert property ((!transfer_direction)[*6] |-> !host_data_oe)
    else $error("data driven on write");
  strobe_idle_a: assert property ((data_strobe_1_n && data_strobe_2_n)[*6] |->
    !host_data_oe) else $error("data driven without strobe");
endmodule // hpc_port_assertions
bind hpc_port hpc_port_assertions hpc_port_assertions_inst(.clk, .rst_n, .float_n,
  .port_chip_select_n, .data_strobe_1_n, .data_strobe_2_n, .transfer_direction,
  .bus_mux_select, .ext_interface_select, .port_reset_n, .host_data_oe, .port_ready_out,
  .port_ready_oe, .subsys_a_host_irq_oe, .subsys_b_host_irq_oe, .subsys_reset_n);

// [bench/hpc_port_tb.sv]
// Self-checking bench of the host port with a host model and Avalon tasks.
// Assumes a 100 MHz clock and read data compared through a queue.
`timescale 1ns/10ps
module hpc_port_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [6:0] avs_address = 7'h00;
  logic [31:0] avs_writedata = 32'h00000000;
  logic bus_mux_select = 1'b0;
  logic ext_interface_select = 1'b0;
  logic float_n = 1'b1;
  logic port_reset_n = 1'b1;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, irq, reg_select_0, reg_select_1, addr_strobe_n, port_chip_select_n;
  wire data_strobe_1_n, data_strobe_2_n, transfer_direction, host_data_oe, port_ready_out;
  wire port_ready_oe, subsys_a_host_irq_n, subsys_a_host_irq_oe, subsys_b_host_irq_n;
  wire subsys_b_host_irq_oe, subsys_reset_n;
  wire [15:0] host_data_in, host_data_out;
  logic [31:0] expq[$];
  logic [31:0] rs = 32'hDED54E3A;
  logic [15:0] q, d1, d2;
  int fail_count = 0;
  int check_count = 0;
  hpc_port hpc_port_inst(.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .irq, .reg_select_0, .reg_select_1, .addr_strobe_n,
    .port_chip_select_n, .data_strobe_1_n, .data_strobe_2_n, .transfer_direction,
    .bus_mux_select, .ext_interface_select, .float_n, .port_reset_n, .host_data_in,
    .host_data_out, .host_data_oe, .port_ready_out, .port_ready_oe, .subsys_a_host_irq_n,
    .subsys_a_host_irq_oe, .subsys_b_host_irq_n, .subsys_b_host_irq_oe, .subsys_reset_n);
  hpc_host_model hpc_host_model_inst(.clk, .port_ready_out, .host_data_out, .host_data_oe,
    .reg_select_0, .reg_select_1, .addr_strobe_n, .port_chip_select_n, .data_strobe_1_n,
    .data_strobe_2_n, .transfer_direction, .host_data_in);
  initial
  begin
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic av(input logic w, input logic [6:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [31:0] exp);
    expq.push_back(exp);
    av(1'b0, a, 32'h00000000);
  endtask
  task automatic pin(input int k, input logic v);
    @(posedge clk);
    case (k)
      0: bus_mux_select <= v;
      1: ext_interface_select <= v;
      2: float_n <= v;
      default: port_reset_n <= v;
    endcase
    repeat (8) @(posedge clk);
  endtask
  // Read data is judged when it stands, against the oldest expectation
  always @(posedge clk)
  begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && expq.size() > 0)
      cmp(avs_readdata, expq.pop_front());
  end
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rs = lfsr(rs);
    d1 = rs[15:0];
    rs = lfsr(rs);
    d2 = rs[15:0];
    hpc_host_model_inst.xfer(2'h2, 1'b0, 16'h0003, q);
    cmp(port_ready_out, 1'b1);
    hpc_host_model_inst.xfer(2'h1, 1'b0, d1, q);
    hpc_host_model_inst.xfer(2'h1, 1'b0, d2, q);
    rd(7'h0C, 32'h5);
    rd(7'h4C, {16'h0, d1});
    rd(7'h50, {16'h0, d2});
    rd(7'h00, 32'h2);
    av(1'b1, 7'h04, 32'h2);
    repeat (3) @(posedge clk);
    cmp(irq, 1'b1);
    av(1'b1, 7'h00, 32'h2);
    repeat (3) @(posedge clk);
    cmp(irq, 1'b0);
    hpc_host_model_inst.alat(16'h0004);
    hpc_host_model_inst.xfer(2'h3, 1'b1, 16'h0000, q);
    cmp({16'h0, q}, {16'h0, d2});
    rd(7'h0C, 32'h4);
    av(1'b1, 7'h08, 32'h18);
    repeat (6) @(posedge clk);
    cmp(subsys_a_host_irq_n, 1'b0);
    cmp(subsys_b_host_irq_n, 1'b0);
    cmp(subsys_b_host_irq_oe, 1'b1);
    hpc_host_model_inst.xfer(2'h0, 1'b0, 16'h0008, q);
    repeat (6) @(posedge clk);
    cmp(subsys_a_host_irq_n, 1'b1);
    cmp(subsys_b_host_irq_n, 1'b0);
    pin(0, 1'b1);
    cmp(subsys_b_host_irq_oe, 1'b0);
    hpc_host_model_inst.xfer(2'h0, 1'b0, 16'h1234, q);
    hpc_host_model_inst.alat(16'h0009);
    pin(0, 1'b0);
    rd(7'h50, 32'h1234);
    rd(7'h0C, 32'h4);
    pin(1, 1'b1);
    cmp(port_ready_oe, 1'b0);
    hpc_host_model_inst.xfer(2'h3, 1'b0, 16'hBEEF, q);
    pin(1, 1'b0);
    rd(7'h50, 32'h1234);
    pin(2, 1'b0);
    cmp(port_ready_oe, 1'b0);
    pin(2, 1'b1);
    cmp(port_ready_oe, 1'b1);
    rd(7'h20, 32'h0);
    pin(3, 1'b0);
    cmp(subsys_reset_n, 1'b0);
    pin(3, 1'b1);
    cmp(subsys_reset_n, 1'b1);
    rd(7'h0C, 32'h0);
    repeat (4) @(posedge clk);
    results();
  end
endmodule // hpc_port_tb

// [design/hpc_consts.vh]
// Constants for the host port pin control block.
// Included by the top design file of the block only; definitions only.
`ifndef HPC_CONSTS_VH
`define HPC_CONSTS_VH
// Register select codes from the two control-select pins
`define HPC_SEL_CTRL 2'h0
`define HPC_SEL_DATA_INC 2'h1
`define HPC_SEL_ADDR 2'h2
`define HPC_SEL_DATA 2'h3
// Port control register bits
`define HPC_CTL_DSPINT 2
`define HPC_CTL_HOST_IRQ_BIT_A 3
`define HPC_CTL_HOST_IRQ_BIT_B 4
// Busy time after a host access, in ns, and in cycles at 10 ns
`define HPC_BUSY_NS 20
`define HPC_CLK_NS 10
`define HPC_BUSY_CYC ((`HPC_BUSY_NS + `HPC_CLK_NS - 1) / `HPC_CLK_NS)
// Avalon byte offsets
`define HPC_OFS_STATUS 7'h00
`define HPC_OFS_MASK 7'h04
`define HPC_OFS_HOSTCTL 7'h08
`define HPC_OFS_ADDR 7'h0C
`define HPC_OFS_PINS 7'h10
`define HPC_OFS_MEM 7'h40
// Status and mask bits
`define HPC_ST_DSPINT 0
`define HPC_ST_HWRITE 1
`define HPC_ST_HREAD 2
`define HPC_ST_W 3
// Shared memory behind the data register
`define HPC_MEM_AW 4
`define HPC_MEM_N 16
`endif

// [design/hpc_port.v]
// Top of the host port: host pins on one side, Avalon-MM slave for the DSP.
// Assumes all host pins are asynchronous; they are synchronised here.
`timescale 1ns/10ps
`include "hpc_consts.vh"
module hpc_port
(
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Avalon-MM slave
  input wire [6:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg irq,
  // Host control pins
  input wire reg_select_0,
  input wire reg_select_1,
  input wire addr_strobe_n,
  input wire port_chip_select_n,
  input wire data_strobe_1_n,
  input wire data_strobe_2_n,
  input wire transfer_direction,
  input wire bus_mux_select,
  input wire ext_interface_select,
  input wire float_n,
  input wire port_reset_n,
  // Host data bus
  input wire [15:0] host_data_in,
  output reg [15:0] host_data_out,
  output reg host_data_oe,
  // Host outputs
  output reg port_ready_out,
  output reg port_ready_oe,
  output reg subsys_a_host_irq_n,
  output reg subsys_a_host_irq_oe,
  output reg subsys_b_host_irq_n,
  output reg subsys_b_host_irq_oe,
  output reg subsys_reset_n
);
reg rst_meta_reg;
reg rst_sync_reg;
wire rst_i;
wire [10:0] pin_s;
wire [15:0] data_s;
wire sel0_s, sel1_s, as_s, cs_s, ds1_s, ds2_s, rw_s, mode_s, xio_s, float_s, prst_s;
wire port_en, mux_mode;
wire xfer_active, xfer_start, xfer_end, addr_latch;
reg [15:0] port_control_reg, port_control_next;
reg [15:0] port_address_reg, port_address_next;
reg [15:0] mem_reg [0:`HPC_MEM_N-1];
reg [1:0] sel_reg;
reg [1:0] busy_cnt_reg;
reg [`HPC_ST_W-1:0] status_reg, status_next;
reg [`HPC_ST_W-1:0] mask_reg;
reg [`HPC_ST_W-1:0] ev;
reg [1:0] sel_eff;
reg host_wr, host_rd, ack;
reg [15:0] rd_val;
wire av_go;
wire [31:0] busy_load;

// Reset release through two flops
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    rst_meta_reg <= 1'b0;
    rst_sync_reg <= 1'b0;
  end
  else
  begin
    rst_meta_reg <= 1'b1;
    rst_sync_reg <= rst_meta_reg;
  end
end
assign rst_i = rst_sync_reg;

hpc_sync #(.W(11)) u_pin_sync
(
  .clk(clk),
  .rst_n(rst_i),
  .d({reg_select_0, reg_select_1, addr_strobe_n, port_chip_select_n, data_strobe_1_n,
      data_strobe_2_n, transfer_direction, bus_mux_select, ext_interface_select, float_n,
      port_reset_n}),
  .q(pin_s)
);
hpc_sync #(.W(16)) u_data_sync
(
  .clk(clk),
  .rst_n(rst_i),
  .d(host_data_in),
  .q(data_s)
);
assign {sel0_s, sel1_s, as_s, cs_s, ds1_s, ds2_s, rw_s, mode_s, xio_s, float_s, prst_s} = pin_s;
// Shared pins belong to the port only in host-port mode and out of port reset
assign port_en = ~xio_s & prst_s;
assign mux_mode = ~mode_s;

hpc_strobe u_strobe
(
  .clk(clk),
  .rst_n(rst_i),
  .cs_n(cs_s),
  .ds1_n(ds1_s),
  .ds2_n(ds2_s),
  .as_n(as_s),
  .enable(port_en),
  .mux_mode(mux_mode),
  .xfer_active(xfer_active),
  .xfer_start(xfer_start),
  .xfer_end(xfer_end),
  .addr_latch(addr_latch)
);

// Register select: non-multiplexed hosts always reach the data register
always @*
begin
  if (mux_mode)
    sel_eff = {sel1_s, sel0_s};
  else
    sel_eff = `HPC_SEL_DATA;
  host_wr = xfer_start & ~rw_s;
  host_rd = xfer_start & rw_s;
end

// Value returned for a host read
always @*
begin
  case (sel_eff)
    `HPC_SEL_CTRL: rd_val = port_control_reg;
    `HPC_SEL_ADDR: rd_val = port_address_reg;
    default: rd_val = mem_reg[port_address_reg[`HPC_MEM_AW-1:0]];
  endcase
end

// Avalon transfer completes in the cycle waitrequest is low
assign av_go = ~avs_waitrequest & (avs_read | avs_write);
assign busy_load = `HPC_BUSY_CYC;

// Control register: host clears irq bits, DSP sets them in multiplexed mode only, DSPINT the reverse, set wins
always @*
begin
  port_control_next = port_control_reg;
  if (host_wr && sel_eff == `HPC_SEL_CTRL)
  begin
    if (data_s[`HPC_CTL_HOST_IRQ_BIT_A])
      port_control_next[`HPC_CTL_HOST_IRQ_BIT_A] = 1'b0;
    if (data_s[`HPC_CTL_HOST_IRQ_BIT_B])
      port_control_next[`HPC_CTL_HOST_IRQ_BIT_B] = 1'b0;
    if (data_s[`HPC_CTL_DSPINT])
      port_control_next[`HPC_CTL_DSPINT] = 1'b1;
  end
  if (av_go && avs_write && avs_address == `HPC_OFS_HOSTCTL)
  begin
    if (avs_writedata[`HPC_CTL_HOST_IRQ_BIT_A])
      port_control_next[`HPC_CTL_HOST_IRQ_BIT_A] = mux_mode;
    if (avs_writedata[`HPC_CTL_HOST_IRQ_BIT_B])
      port_control_next[`HPC_CTL_HOST_IRQ_BIT_B] = mux_mode;
    // A host set in the same cycle beats this clear
    if (avs_writedata[`HPC_CTL_DSPINT] && !ev[`HPC_ST_DSPINT])
      port_control_next[`HPC_CTL_DSPINT] = 1'b0;
  end
  if (!mux_mode)
  begin
    port_control_next[`HPC_CTL_HOST_IRQ_BIT_A] = 1'b0;
    port_control_next[`HPC_CTL_HOST_IRQ_BIT_B] = 1'b0;
  end
end

// Address register: strobe latch, host write, auto increment
always @*
begin
  port_address_next = port_address_reg;
  if (addr_latch)
    port_address_next = data_s;
  else if (host_wr && sel_eff == `HPC_SEL_ADDR)
    port_address_next = data_s;
  else if (xfer_start && sel_eff == `HPC_SEL_DATA_INC)
    port_address_next = port_address_reg + 16'h0001;
end

// Status events; a new event beats a write-one clear
always @*
begin
  ev = {`HPC_ST_W{1'b0}};
  ev[`HPC_ST_DSPINT] = host_wr & (sel_eff == `HPC_SEL_CTRL) & data_s[`HPC_CTL_DSPINT];
  ev[`HPC_ST_HWRITE] = host_wr & (sel_eff[0] == 1'b1);
  ev[`HPC_ST_HREAD] = host_rd & (sel_eff[0] == 1'b1);
  status_next = status_reg;
  if (av_go && avs_write && avs_address == `HPC_OFS_STATUS)
    status_next = status_reg & ~avs_writedata[`HPC_ST_W-1:0];
  status_next = status_next | ev;
end

// Port-side registers; the port reset pin clears control, address and busy count synchronously
always @(posedge clk or negedge rst_i)
begin
  if (!rst_i)
  begin
    port_control_reg <= 16'h0000;
    port_address_reg <= 16'h0000;
    sel_reg <= `HPC_SEL_CTRL;
    busy_cnt_reg <= 2'h0;
    status_reg <= {`HPC_ST_W{1'b0}};
    mask_reg <= {`HPC_ST_W{1'b0}};
    subsys_reset_n <= 1'b0;
  end
  else
  begin
    subsys_reset_n <= prst_s;
    status_reg <= status_next;
    if (av_go && avs_write && avs_address == `HPC_OFS_MASK)
      mask_reg <= avs_writedata[`HPC_ST_W-1:0];
    if (!prst_s)
    begin
      port_control_reg <= 16'h0000;
      port_address_reg <= 16'h0000;
      busy_cnt_reg <= 2'h0;
    end
    else
    begin
      port_control_reg <= port_control_next;
      port_address_reg <= port_address_next;
      if (xfer_start)
        sel_reg <= sel_eff;
      // Ready drops for a short time after each strobe ends
      if (xfer_end)
        busy_cnt_reg <= busy_load[1:0];
      else if (busy_cnt_reg != 2'h0)
        busy_cnt_reg <= busy_cnt_reg - 2'h1;
    end
  end
end

// Shared memory: host write first, DSP write otherwise
always @(posedge clk)
begin
  if (host_wr && sel_eff[0])
    mem_reg[port_address_reg[`HPC_MEM_AW-1:0]] <= data_s;
  else if (av_go && avs_write && avs_address[6] && !avs_address[1] && !avs_address[0])
    mem_reg[avs_address[`HPC_MEM_AW+1:2]] <= avs_writedata[15:0];
end

// Pin drivers; float and interface select override everything
always @(posedge clk or negedge rst_i)
begin
  if (!rst_i)
  begin
    host_data_out <= 16'h0000;
    host_data_oe <= 1'b0;
    port_ready_out <= 1'b0;
    port_ready_oe <= 1'b0;
    subsys_a_host_irq_n <= 1'b1;
    subsys_a_host_irq_oe <= 1'b0;
    subsys_b_host_irq_n <= 1'b1;
    subsys_b_host_irq_oe <= 1'b0;
  end
  else
  begin
    if (host_rd)
      host_data_out <= rd_val;
    // Data held out only while the read strobe stays active
    host_data_oe <= float_s & port_en & (xfer_start | (xfer_active & ~xfer_end)) & rw_s
      & (host_rd | host_data_oe);
    // Ready drops in the cycle the strobe is seen, so it never overlaps read data
    port_ready_out <= ~(xfer_start | xfer_active) & (busy_cnt_reg == 2'h0) & ~xfer_end;
    port_ready_oe <= float_s & port_en;
    subsys_a_host_irq_n <= ~port_control_next[`HPC_CTL_HOST_IRQ_BIT_A];
    subsys_b_host_irq_n <= ~port_control_next[`HPC_CTL_HOST_IRQ_BIT_B];
    subsys_a_host_irq_oe <= float_s & port_en & mux_mode;
    subsys_b_host_irq_oe <= float_s & port_en & mux_mode;
  end
end

// Avalon slave: one wait cycle per request, answer registered
always @(posedge clk or negedge rst_i)
begin
  if (!rst_i)
  begin
    avs_waitrequest <= 1'b1;
    avs_readdata <= 32'h00000000;
    irq <= 1'b0;
  end
  else
  begin
    avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    irq <= |(status_next & mask_reg);
    if ((avs_read | avs_write) && avs_waitrequest)
    begin
      avs_readdata <= 32'h00000000;
      if (avs_read)
      begin
        if (avs_address[6])
          avs_readdata <= {16'h0000, mem_reg[avs_address[`HPC_MEM_AW+1:2]]};
        else
        begin
          case (avs_address)
            `HPC_OFS_STATUS: avs_readdata <= {29'h00000000, status_reg};
            `HPC_OFS_MASK: avs_readdata <= {29'h00000000, mask_reg};
            `HPC_OFS_HOSTCTL: avs_readdata <= {16'h0000, port_control_reg};
            `HPC_OFS_ADDR: avs_readdata <= {16'h0000, port_address_reg};
            `HPC_OFS_PINS: avs_readdata <= {26'h0000000, sel_reg, float_s, xio_s, mode_s, prst_s};
            default: avs_readdata <= 32'h00000000;
          endcase
        end
      end
    end
  end
end
endmodule // hpc_port

// [design/hpc_strobe.v]
// Forms the internal transfer strobe from synchronised host pins.
// Assumes its inputs already passed a synchroniser.
`timescale 1ns/10ps
module hpc_strobe
(
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Synchronised host pins
  input wire cs_n,
  input wire ds1_n,
  input wire ds2_n,
  input wire as_n,
  input wire enable,
  input wire mux_mode,
  // Events
  output reg xfer_active,
  output wire xfer_start,
  output wire xfer_end,
  output wire addr_latch
);
reg act_prev_reg;
reg as_prev_reg;
wire act_now;
// Exactly one strobe low, gated by chip select; both low is no transfer
assign act_now = enable & ~cs_n & (ds1_n ^ ds2_n);
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    act_prev_reg <= 1'b0;
    as_prev_reg <= 1'b1;
    xfer_active <= 1'b0;
  end
  else
  begin
    act_prev_reg <= act_now;
    as_prev_reg <= as_n;
    xfer_active <= act_now;
  end
end
assign xfer_start = act_now & ~act_prev_reg;
assign xfer_end = ~act_now & act_prev_reg;
// Strobe only counts in multiplexed mode
assign addr_latch = enable & mux_mode & ~as_n & as_prev_reg;
endmodule // hpc_strobe

// [design/hpc_sync.v]
// Two-flop synchroniser for a bus of independent levels.
// Assumes each bit is a slow level; no word coherence is promised.
`timescale 1ns/10ps
module hpc_sync #(parameter W = 1)
(
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Levels
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
reg [W-1:0] meta_reg;
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    meta_reg <= {W{1'b1}};
    q <= {W{1'b1}};
  end
  else
  begin
    meta_reg <= d;
    q <= meta_reg;
  end
end
endmodule // hpc_sync
